// [design/paired_timer_map.svh]
// register offsets, field positions, reset values and counts of the paired timer
// assumes inclusion by bare name from the design files
`ifndef PAIRED_TIMER_MAP_SVH
`define PAIRED_TIMER_MAP_SVH
`define OFS_LOW_CTRL      12'h000
`define OFS_HIGH_CTRL     12'h004
`define OFS_LOW_COUNT     12'h008
`define OFS_HIGH_COUNT    12'h00C
`define OFS_LOW_PERIOD    12'h010
`define OFS_HIGH_PERIOD   12'h014
`define OFS_IRQ_STATUS    12'h018
`define OFS_IRQ_MASK      12'h01C
`define BIT_RUN           15
`define BIT_IDLE_STOP     13
`define BIT_GATE          6
`define BIT_PS_HI         5
`define BIT_PS_LO         4
`define BIT_PAIR          3
`define BIT_CLK_SRC       1
`define LOW_CTRL_MASK     16'hA07A
`define HIGH_CTRL_MASK    16'hA072
`define CTRL_RESET        16'h0000
`define PERIOD_RESET      16'hFFFF
`define IRQ_LOW           0
`define IRQ_HIGH          1
`define DIV_8             8'h07
`define DIV_64            8'h3F
`define DIV_256           8'hFF
`endif

// [design/paired_timer_pkg.sv]
// types shared by the paired timer files
// assumes nothing of its surroundings
package paired_timer_pkg;
    typedef logic [15:0] word_t;
    typedef logic [7:0]  pscnt_t;
    typedef logic [1:0]  pssel_t;
endpackage

// [design/timer_slice.sv]
// one 16-bit timer slice: prescaler, gate, counter, period match
// assumes its tick source is already synchronized to mclk
`timescale 1ns/10ps
`default_nettype none
`include "paired_timer_map.svh"
module timer_slice
(
    input  wire logic                     mclk,
    input  wire logic                     resetn,
    input  wire logic                     enable,
    input  wire logic                     src_tick,
    input  wire logic                     gate_mode,
    input  wire logic                     gate_level,
    input  wire paired_timer_pkg::pssel_t ps_sel,
    input  wire paired_timer_pkg::word_t  period,
    input  wire logic                     wr_count,
    input  wire paired_timer_pkg::word_t  wr_data,
    input  wire logic                     carry_in,
    input  wire logic                     chained,
    output logic                          tick_out,
    output logic                          match,
    output paired_timer_pkg::word_t       count_q
);
    import paired_timer_pkg::*;

    function automatic pscnt_t div_limit(input pssel_t s);
        unique case (s)
            2'b00: div_limit = 8'h00;
            2'b01: div_limit = `DIV_8;
            2'b10: div_limit = `DIV_64;
            2'b11: div_limit = `DIV_256;
        endcase
    endfunction

    pscnt_t ps_q;
    pscnt_t ps_d;
    word_t  count_d;
    logic   adv;

    always_comb
    begin
        ps_d     = ps_q;
        tick_out = 1'b0;
        if (!enable || chained)
            ps_d = 8'h00;
        else if (src_tick && (!gate_mode || gate_level))
        begin
            if (ps_q >= div_limit(ps_sel))
            begin
                ps_d     = 8'h00;
                tick_out = 1'b1;
            end
            else
                ps_d = ps_q + 8'h01;
        end
        adv     = chained ? carry_in : tick_out;
        match   = adv && (count_q == period);
        count_d = count_q;
        if (wr_count)
            count_d = wr_data;
        else if (adv)
            count_d = match ? 16'h0000 : count_q + 16'h0001;
    end

    always_ff @(posedge mclk)
    begin
        if (!resetn)
        begin
            ps_q    <= 8'h00;
            count_q <= 16'h0000;
        end
        else
        begin
            ps_q    <= ps_d;
            count_q <= count_d;
        end
    end
endmodule
`default_nettype wire

// [design/paired_timer_control.sv]
// Functional notes
// - paired: low run bit starts/stops 32-bit
// - unpaired: each run bit controls its timer
// - idle-stop set halts timer in idle
// - gate honoured only with internal clock
// - prescale codes divide 1, 8, 64, 256
// - pair bit joins timers into 32 bits
// - clock source: external pin or internal
// - unimplemented control bits read zero
// - high control bits other than idle-stop ignored when paired
// - paired idle run needs high idle-stop clear
// - control bits read/write, reset to zero
// - high word msw, low word lsw
// - paired uses high interrupt, low ignored
// - external pin synchronized before use
//
// paired 16/32-bit timer with APB register access and one interrupt
// assumes mclk is the internal instruction clock; pins are asynchronous
//
// Implementation choices: the placing of the registers and the APB slave port.
`timescale 1ns/10ps
`default_nettype none
`include "paired_timer_map.svh"
module paired_timer_control
(
    input  wire logic        mclk,
    input  wire logic        resetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        idle_mode,
    input  wire logic        low_count_pin,
    input  wire logic        high_count_pin,
    input  wire logic        low_gate_pin,
    input  wire logic        high_gate_pin,
    output logic             irq
);
    import paired_timer_pkg::*;

    word_t       lctl_q, lctl_d, hctl_q, hctl_d;
    word_t       lper_q, lper_d, hper_q, hper_d;
    logic [1:0]  ist_q, ist_d, imsk_q, imsk_d;
    logic [31:0] prdata_d;
    logic [2:0]  lpin_s, hpin_s, lgate_s, hgate_s;
    logic        lgate_fall, hgate_fall;
    logic        pair, l_run, h_run, l_ext, h_ext, l_gate, h_gate;
    logic        l_src, h_src, l_tick, h_tick, l_match, h_match;
    logic        wr_lcnt, wr_hcnt;
    word_t       lcnt, hcnt;
    logic        acc, wr;
    logic [1:0]  ev;

    assign acc     = psel && penable;
    assign wr      = acc && pwrite;
    assign pready  = 1'b1;
    assign pslverr = 1'b0;

    // two-stage synchronizers, third stage for edge detection
    always_ff @(posedge mclk)
    begin
        if (!resetn)
        begin
            lpin_s  <= 3'b000;
            hpin_s  <= 3'b000;
            lgate_s <= 3'b000;
            hgate_s <= 3'b000;
        end
        else
        begin
            lpin_s  <= {lpin_s[1:0], low_count_pin};
            hpin_s  <= {hpin_s[1:0], high_count_pin};
            lgate_s <= {lgate_s[1:0], low_gate_pin};
            hgate_s <= {hgate_s[1:0], high_gate_pin};
        end
    end

    assign pair    = lctl_q[`BIT_PAIR];
    // run qualified by idle-stop; paired mode uses high idle-stop only
    assign l_run   = lctl_q[`BIT_RUN] && !(idle_mode &&
                     (pair ? hctl_q[`BIT_IDLE_STOP] : lctl_q[`BIT_IDLE_STOP]));
    assign h_run   = !pair && hctl_q[`BIT_RUN] &&
                     !(idle_mode && hctl_q[`BIT_IDLE_STOP]);
    assign l_ext   = lctl_q[`BIT_CLK_SRC];
    assign h_ext   = hctl_q[`BIT_CLK_SRC];
    assign l_gate  = !l_ext && lctl_q[`BIT_GATE];
    assign h_gate  = !h_ext && hctl_q[`BIT_GATE];
    assign l_src   = l_ext ? (lpin_s[1] && !lpin_s[2]) : 1'b1;
    assign h_src   = h_ext ? (hpin_s[1] && !hpin_s[2]) : 1'b1;
    assign lgate_fall = l_gate && l_run && lgate_s[2] && !lgate_s[1];
    assign hgate_fall = h_gate && h_run && hgate_s[2] && !hgate_s[1];
    assign wr_lcnt = wr && paddr == `OFS_LOW_COUNT;
    assign wr_hcnt = wr && paddr == `OFS_HIGH_COUNT;

    timer_slice u_low
    (
        .mclk       (mclk),
        .resetn     (resetn),
        .enable     (l_run),
        .src_tick   (l_src),
        .gate_mode  (l_gate),
        .gate_level (lgate_s[1]),
        .ps_sel     (lctl_q[`BIT_PS_HI:`BIT_PS_LO]),
        .period     (lper_q),
        .wr_count   (wr_lcnt),
        .wr_data    (pwdata[15:0]),
        .carry_in   (1'b0),
        .chained    (1'b0),
        .tick_out   (l_tick),
        .match      (l_match),
        .count_q    (lcnt)
    );

    // paired: high slice advances when low ticks at FFFF; match needs both words
    timer_slice u_high
    (
        .mclk       (mclk),
        .resetn     (resetn),
        .enable     (h_run),
        .src_tick   (h_src),
        .gate_mode  (h_gate),
        .gate_level (hgate_s[1]),
        .ps_sel     (hctl_q[`BIT_PS_HI:`BIT_PS_LO]),
        .period     (pair ? hper_q : hper_q),
        .wr_count   (wr_hcnt),
        .wr_data    (pwdata[15:0]),
        .carry_in   (l_tick && lcnt == 16'hFFFF),
        .chained    (pair),
        .tick_out   (h_tick),
        .match      (h_match),
        .count_q    (hcnt)
    );

    logic pair_wrap;
    logic pair_match;
    assign pair_match = l_tick && lcnt == lper_q && hcnt == hper_q;
    assign pair_wrap  = pair_match;

    always_comb
    begin
        lctl_d = lctl_q;
        hctl_d = hctl_q;
        lper_d = lper_q;
        hper_d = hper_q;
        imsk_d = imsk_q;
        ev     = 2'b00;
        if (pair)
            ev[`IRQ_HIGH] = pair_match || lgate_fall;
        else
        begin
            ev[`IRQ_LOW]  = (l_match && !(lcnt == 16'hFFFF && 1'b0)) || lgate_fall;
            ev[`IRQ_HIGH] = h_match || hgate_fall;
        end
        ist_d = ist_q;
        if (wr)
        begin
            unique case (paddr)
                `OFS_LOW_CTRL:    lctl_d = pwdata[15:0] & `LOW_CTRL_MASK;
                `OFS_HIGH_CTRL:   hctl_d = pwdata[15:0] & `HIGH_CTRL_MASK;
                `OFS_LOW_PERIOD:  lper_d = pwdata[15:0];
                `OFS_HIGH_PERIOD: hper_d = pwdata[15:0];
                `OFS_IRQ_STATUS:  ist_d  = ist_q & ~pwdata[1:0];
                `OFS_IRQ_MASK:    imsk_d = pwdata[1:0];
                default:          ;
            endcase
        end
        ist_d = ist_d | ev;
        prdata_d = 32'h0000_0000;
        if (psel && !penable && !pwrite)
        begin
            unique case (paddr)
                `OFS_LOW_CTRL:    prdata_d = {16'h0000, lctl_q};
                `OFS_HIGH_CTRL:   prdata_d = {16'h0000, hctl_q};
                `OFS_LOW_COUNT:   prdata_d = {16'h0000, lcnt};
                `OFS_HIGH_COUNT:  prdata_d = {16'h0000, hcnt};
                `OFS_LOW_PERIOD:  prdata_d = {16'h0000, lper_q};
                `OFS_HIGH_PERIOD: prdata_d = {16'h0000, hper_q};
                `OFS_IRQ_STATUS:  prdata_d = {30'h0000_0000, ist_q};
                `OFS_IRQ_MASK:    prdata_d = {30'h0000_0000, imsk_q};
                default:          prdata_d = 32'h0000_0000;
            endcase
        end
        else if (acc)
            prdata_d = prdata;
    end

    always_ff @(posedge mclk)
    begin
        if (!resetn)
        begin
            lctl_q <= `CTRL_RESET;
            hctl_q <= `CTRL_RESET;
            lper_q <= `PERIOD_RESET;
            hper_q <= `PERIOD_RESET;
            ist_q  <= 2'b00;
            imsk_q <= 2'b00;
            prdata <= 32'h0000_0000;
        end
        else
        begin
            lctl_q <= lctl_d;
            hctl_q <= hctl_d;
            lper_q <= lper_d;
            hper_q <= hper_d;
            ist_q  <= ist_d;
            imsk_q <= imsk_d;
            prdata <= prdata_d;
        end
    end

    assign irq = |(ist_q & imsk_q);

    a_unimpl_zero: assert property (@(posedge mclk) disable iff (!resetn)
        (lctl_q & ~`LOW_CTRL_MASK) == 16'h0000 && (hctl_q & ~`HIGH_CTRL_MASK) == 16'h0000)
        else $error("unimplemented control bit set");
    a_ctrl_write: assert property (@(posedge mclk) disable iff (!resetn)
        wr && paddr == `OFS_LOW_CTRL |=> lctl_q == ($past(pwdata[15:0]) & `LOW_CTRL_MASK))
        else $error("low control write lost");
    a_stop_halts: assert property (@(posedge mclk) disable iff (!resetn)
        !lctl_q[`BIT_RUN] && !wr_lcnt |=> $stable(lcnt))
        else $error("low counter moved while stopped");
    a_idle_halts: assert property (@(posedge mclk) disable iff (!resetn)
        idle_mode && !pair && lctl_q[`BIT_IDLE_STOP] && !wr_lcnt |=> $stable(lcnt))
        else $error("low counter moved in idle");
    a_high_ignored: assert property (@(posedge mclk) disable iff (!resetn)
        pair && !l_tick && !wr_hcnt |=> $stable(hcnt))
        else $error("high word moved without carry");
    a_free_count: assert property (@(posedge mclk) disable iff (!resetn)
        l_run && !l_ext && !l_gate && lctl_q[5:4] == 2'b00 && !wr_lcnt && lcnt != lper_q
        |=> lcnt == $past(lcnt) + 16'h0001)
        else $error("low counter failed to advance");
    a_wrap_flag: assert property (@(posedge mclk) disable iff (!resetn)
        !pair && l_match && !wr_lcnt |=> lcnt == 16'h0000 && ist_q[`IRQ_LOW])
        else $error("period match not handled");
    a_pair_irq: assert property (@(posedge mclk) disable iff (!resetn)
        pair && pair_match |=> ist_q[`IRQ_HIGH])
        else $error("paired match missed high flag");
    a_irq_level: assert property (@(posedge mclk) disable iff (!resetn)
        irq == |(ist_q & imsk_q))
        else $error("interrupt output mismatch");
endmodule
`default_nettype wire

// [bench/tb_paired_timer_control.sv]
// self-checking bench of the paired timer over apb
// assumes zero-wait apb slave and the register map header
`timescale 1ns/10ps
`default_nettype none
`include "paired_timer_map.svh"
module tb_paired_timer_control;
    logic        mclk = 0, resetn = 0, psel = 0, penable = 0, pwrite = 0;
    logic [11:0] paddr = '0;
    logic [31:0] pwdata = '0, prdata, v;
    logic        pready, pslverr, irq, idle_mode = 0;
    logic        lpin = 0, hpin = 0, lgate = 0, hgate = 0;
    int          mismatches = 0, check_count = 0, cyc = 0;
    localparam logic [31:0] RUN = 32'h0000_8000, IDL = 32'h0000_2000, GATE = 32'h0000_0040;
    localparam logic [31:0] PAIR = 32'h0000_0008, EXT = 32'h0000_0002;
    paired_timer_control dut_u (.mclk(mclk), .resetn(resetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .idle_mode(idle_mode), .low_count_pin(lpin), .high_count_pin(hpin),
        .low_gate_pin(lgate), .high_gate_pin(hgate), .irq(irq));
    always #12.5 mclk = ~mclk;
    task automatic results();
        $display("checks %0d mismatches %0d", check_count, mismatches);
        if (mismatches == 0 && check_count > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    always @(posedge mclk)
    begin
        cyc++;
        if (cyc == 60000)
        begin
            mismatches++;
            results();
        end
    end
    task automatic chk(string n, logic [31:0] e, logic [31:0] g);
        check_count++;
        if (g !== e)
        begin
            mismatches++;
            $display("[ERR] %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic rng(string n, logic [31:0] lo, logic [31:0] hi, logic [31:0] g);
        check_count++;
        if (!(g >= lo && g <= hi) || $isunknown(g))
        begin
            mismatches++;
            $display("[ERR] %s expected %0d..%0d seen %0d", n, lo, hi, g);
        end
    endtask
    task automatic xfer(logic w, logic [11:0] a, logic [31:0] d, output logic [31:0] r);
        @(posedge mclk);
        psel <= 1; pwrite <= w; paddr <= a; pwdata <= d; penable <= 0;
        @(posedge mclk);
        penable <= 1;
        do
            @(posedge mclk);
        while (pready !== 1'b1);
        r = prdata;
        chk("pslverr", 0, pslverr);
        psel <= 0; penable <= 0;
    endtask
    task automatic wr(logic [11:0] a, logic [31:0] d);
        logic [31:0] r;
        xfer(1, a, d, r);
    endtask
    task automatic rd(logic [11:0] a, output logic [31:0] r);
        xfer(0, a, 0, r);
    endtask
    task automatic wait_cyc(int n);
        repeat (n) @(posedge mclk);
    endtask
    task automatic regs_test();
        rd(`OFS_LOW_CTRL, v);  chk("low ctrl reset", 0, v);
        rd(`OFS_HIGH_CTRL, v); chk("high ctrl reset", 0, v);
        wr(`OFS_LOW_CTRL, 32'hFFFF_7F05); rd(`OFS_LOW_CTRL, v);
        chk("low ctrl mask", 32'h0000_2000, v);
        wr(`OFS_HIGH_CTRL, 32'h0000_FFFF); rd(`OFS_HIGH_CTRL, v);
        chk("high ctrl mask", 32'h0000_A072, v);
        wr(`OFS_LOW_CTRL, 0); wr(`OFS_HIGH_CTRL, 0);
        rd(12'h040, v); chk("unmapped", 0, v);
    endtask
    task automatic presc_test();
        for (int c = 0; c < 4; c++)
        begin
            int dv = (c == 0) ? 1 : (c == 1) ? 8 : (c == 2) ? 64 : 256;
            wr(`OFS_LOW_COUNT, 0);
            wr(`OFS_LOW_CTRL, RUN | (c << 4));
            wait_cyc(16 * dv);
            wr(`OFS_LOW_CTRL, 0);
            rd(`OFS_LOW_COUNT, v);
            rng("prescaled count", 15, 17 + 3 / dv, v);
        end
    endtask
    task automatic irq_test();
        wr(`OFS_LOW_COUNT, 0); wr(`OFS_LOW_PERIOD, 3); wr(`OFS_IRQ_MASK, 1);
        wr(`OFS_LOW_CTRL, RUN); wait_cyc(20);
        chk("irq on match", 1, irq);
        wr(`OFS_LOW_CTRL, 0); rd(`OFS_LOW_COUNT, v);
        rng("wrapped count", 0, 3, v);
        wr(`OFS_IRQ_MASK, 0); wait_cyc(1); chk("irq masked", 0, irq);
        wr(`OFS_IRQ_STATUS, 1); rd(`OFS_IRQ_STATUS, v);
        chk("status cleared", 0, v);
        wr(`OFS_LOW_PERIOD, 32'h0000_FFFF);
    endtask
    task automatic idle_test();
        wr(`OFS_LOW_COUNT, 0); idle_mode <= 1;
        wr(`OFS_LOW_CTRL, RUN | IDL); wait_cyc(30); wr(`OFS_LOW_CTRL, 0);
        rd(`OFS_LOW_COUNT, v); chk("idle halted", 0, v);
        wr(`OFS_LOW_CTRL, RUN); wait_cyc(30); wr(`OFS_LOW_CTRL, 0);
        rd(`OFS_LOW_COUNT, v); rng("idle running", 30, 34, v);
        idle_mode <= 0;
    endtask
    task automatic pair_test();
        wr(`OFS_LOW_COUNT, 32'h0000_FFF0); wr(`OFS_HIGH_COUNT, 0);
        wr(`OFS_HIGH_CTRL, GATE | 32'h0000_0032);
        wr(`OFS_LOW_CTRL, RUN | PAIR); wait_cyc(40); wr(`OFS_LOW_CTRL, PAIR);
        rd(`OFS_HIGH_COUNT, v); chk("high word", 1, v);
        rd(`OFS_LOW_COUNT, v); rng("low word", 24, 28, v);
        wr(`OFS_HIGH_CTRL, IDL); idle_mode <= 1;
        wr(`OFS_LOW_CTRL, RUN | PAIR); wait_cyc(30); wr(`OFS_LOW_CTRL, 0);
        rd(`OFS_LOW_COUNT, v); rng("paired idle", 24, 28, v);
        idle_mode <= 0; wr(`OFS_HIGH_CTRL, 0);
    endtask
    task automatic ext_test();
        wr(`OFS_LOW_COUNT, 0); lgate <= 0;
        wr(`OFS_LOW_CTRL, RUN | EXT | GATE); wait_cyc(20);
        repeat (5)
        begin
            lpin <= 1; wait_cyc(4); lpin <= 0; wait_cyc(4);
        end
        wait_cyc(4); wr(`OFS_LOW_CTRL, 0);
        rd(`OFS_LOW_COUNT, v); chk("pin edges", 5, v);
    endtask
    task automatic gate_test();
        wr(`OFS_LOW_COUNT, 0); wr(`OFS_LOW_CTRL, RUN | GATE); wait_cyc(30);
        rd(`OFS_LOW_COUNT, v); chk("gate low", 0, v);
        lgate <= 1; wait_cyc(30); lgate <= 0; wait_cyc(6); wr(`OFS_LOW_CTRL, 0);
        rd(`OFS_LOW_COUNT, v); rng("gate high", 28, 33, v);
        rd(`OFS_IRQ_STATUS, v); chk("gate fall flag", 1, v & 1);
    endtask
    initial
    begin
        wait_cyc(12);
        resetn <= 1;
        regs_test();
        presc_test();
        irq_test();
        idle_test();
        pair_test();
        ext_test();
        gate_test();
        results();
    end
endmodule
`default_nettype wire
